// [verification/cssr_card_model.sv]
// Card inserted in the socket, driving the status pins
// Assumes the bench changes inputs just after clk_i edges
`timescale 1ns/1ps

module cssr_card_model (
  input  wire logic       present_i,
  input  wire logic       partial_i,
  input  wire logic       ready_i,
  input  wire logic       wp_i,
  input  wire logic [1:0] lvl_i,
  output logic            ready_o,
  output logic            wp_o,
  output logic            det_a_n_o,
  output logic            det_b_n_o,
  output logic [1:0]      lvl_o
);
  // Detect lines pulled high with no card; half-seated card closes only A
  assign det_a_n_o = !present_i;
  assign det_b_n_o = !(present_i && !partial_i);
  assign ready_o   = present_i & ready_i;
  assign wp_o      = present_i & wp_i;
  assign lvl_o     = present_i ? lvl_i : 2'h0;
endmodule : cssr_card_model

// [verification/cssr_regs_sva.sv]
// Port assertions for the socket id/status register bank
// Assumes a classic Wishbone master holding requests until ack
`timescale 1ns/1ps

module cssr_regs_chk #(
  parameter int ADR_W = 16
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             card_ready_i,
  input wire logic             card_wp_i,
  input wire logic             card_detect_a_pin_n_i,
  input wire logic             card_detect_b_pin_n_i,
  input wire logic             battery_detect_a_i,
  input wire logic             battery_detect_b_i,
  input wire logic [4:0]       mem_win_hit_i,
  input wire logic             mem_wr_req_i,
  input wire logic             mem_wr_allow_o,
  input wire logic             socket_power_o
);
  logic [6:0] h_q [4];
  logic [6:0] h_d [4];
  logic [6:0] pv;
  logic       rd_st;
  logic       stab;
  assign pv = {1'b1, card_ready_i, card_wp_i, card_detect_b_pin_n_i,
               card_detect_a_pin_n_i, battery_detect_b_i, battery_detect_a_i};
  assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i == 16'h2004;
  assign stab = h_q[0] == pv && h_q[1] == pv && h_q[2] == pv && h_q[3] == pv;
  // Pin history; valid flag cleared by reset
  always_comb begin
    h_d = '{pv, h_q[0], h_q[1], h_q[2]};
    if (rst_i) h_d = '{default: 7'h00};
  end
  always_ff @(posedge clk_i) h_q <= h_d;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_req; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack");
  property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper data set");
  property p_id_type;
    wb_ack_o && !wb_we_i && wb_adr_i == 16'h2000 |-> wb_dat_o[7:6] == 2'h2;
  endproperty
  a_id_type: assert property (p_id_type) else $error("bad type");
  property p_st_rsvd; rd_st |-> !wb_dat_o[7]; endproperty
  a_st_rsvd: assert property (p_st_rsvd) else $error("bit 7 set");
  property p_st_pwr; rd_st |-> wb_dat_o[6] == socket_power_o; endproperty
  a_st_pwr: assert property (p_st_pwr) else $error("bad power bit");
  property p_st_det; rd_st && stab |-> wb_dat_o[3:2] == ~pv[3:2]; endproperty
  a_st_det: assert property (p_st_det) else $error("bad detect");
  property p_st_rdwp; rd_st && stab |-> wb_dat_o[5:4] == pv[5:4]; endproperty
  a_st_rdwp: assert property (p_st_rdwp) else $error("bad ready/wp");
  property p_st_lvl; rd_st && stab |-> wb_dat_o[1:0] == pv[1:0]; endproperty
  a_st_lvl: assert property (p_st_lvl) else $error("bad low bits");
  property p_allow; !$past(mem_wr_req_i) |-> !mem_wr_allow_o; endproperty
  a_allow: assert property (p_allow) else $error("allow no req");
  property p_allow_nohit;
    !$past(rst_i) && $past(mem_wr_req_i && mem_win_hit_i == 5'h00) |-> mem_wr_allow_o;
  endproperty
  a_allow_nohit: assert property (p_allow_nohit) else $error("blocked");
endmodule : cssr_regs_chk

bind cssr_regs cssr_regs_chk #(.ADR_W(ADR_W)) i_cssr_regs_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .card_ready_i(card_ready_i), .card_wp_i(card_wp_i),
  .card_detect_a_pin_n_i(card_detect_a_pin_n_i),
  .card_detect_b_pin_n_i(card_detect_b_pin_n_i),
  .battery_detect_a_i(battery_detect_a_i), .battery_detect_b_i(battery_detect_b_i),
  .mem_win_hit_i(mem_win_hit_i), .mem_wr_req_i(mem_wr_req_i),
  .mem_wr_allow_o(mem_wr_allow_o), .socket_power_o(socket_power_o));

// [verification/cssr_tb_top.sv]
// Self-checking bench for the socket id/status register bank
// Assumes cssr_regs on classic Wishbone, card model on the pins
`timescale 1ns/1ps

module card_socket_id_and_status_regs_tb_top;
  localparam logic [3:0] CREV = 4'h1; // Arbitrary value
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, req = 1'b0, allow;
  logic [15:0] adr = 16'h0000;
  logic [31:0] dat = 32'h0, rdat;
  logic        p_rdy, p_wp, p_da, p_db, legacy, pwr, isio;
  logic [1:0]  p_lvl, c_lvl = 2'h0;
  logic        c_pres = 1'b0, c_rdy = 1'b0, c_wp = 1'b0, c_part = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [4:0]  hit = 5'h00;
  int          n_mismatch = 0, num_checks = 0;

  cssr_regs #(.ADR_W(16), .COMPAT_REV(CREV)) i_cssr_regs (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .card_ready_i(p_rdy), .card_wp_i(p_wp), .card_detect_a_pin_n_i(p_da),
    .card_detect_b_pin_n_i(p_db), .battery_detect_a_i(p_lvl[0]),
    .battery_detect_b_i(p_lvl[1]), .mem_win_hit_i(hit), .mem_wr_req_i(req),
    .mem_wr_allow_o(allow), .legacy_mode_o(legacy), .socket_power_o(pwr),
    .card_is_io_o(isio));
  cssr_card_model i_cssr_card_model (
    .present_i(c_pres), .partial_i(c_part), .ready_i(c_rdy), .wp_i(c_wp), .lvl_i(c_lvl),
    .ready_o(p_rdy),
    .wp_o(p_wp), .det_a_n_o(p_da), .det_b_n_o(p_db), .lvl_o(p_lvl));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'h1;
    adr <= a;
    dat <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    if (i == 20) begin
      n_mismatch++;
      test_done;
    end
  endtask : wb

  task automatic t_id;
    logic [31:0] q;
    wb(1'b0, 16'h2000, 8'h00, q);
    chk(q, {24'h0, 2'h2, 2'h0, CREV});
    wb(1'b0, 16'h2FFC, 8'h00, q);
    chk(q, 32'h0);
    wb(1'b1, 16'h2000, 8'hFF, q);
    wb(1'b0, 16'h2000, 8'h00, q);
    chk(q, {24'h0, 2'h2, 2'h0, CREV});
    wb(1'b1, 16'h23C0, 8'h20, q);
    wb(1'b1, 16'h2000, 8'h32, q);
    wb(1'b0, 16'h2000, 8'h00, q);
    chk(q, 32'h0000_00B2);
    chk({31'h0, legacy}, 32'h1);
    wb(1'b1, 16'h2008, 8'hFF, q);
    wb(1'b0, 16'h2008, 8'h00, q);
    chk(q, 32'h0000_009B);
    wb(1'b1, 16'h2000, 8'h05, q);
    wb(1'b1, 16'h2008, 8'hFF, q);
    wb(1'b0, 16'h2008, 8'h00, q);
    chk(q, 32'h0000_00B3);
    chk({31'h0, legacy}, 32'h0);
    chk({31'h0, pwr}, 32'h1);
    wb(1'b0, 16'h2004, 8'h00, q);
    chk(q, 32'h0000_0040);
    wb(1'b1, 16'h2008, 8'h00, q);
  endtask : t_id

  task automatic t_status;
    logic [31:0] q;
    @(posedge clk_i);
    c_pres <= 1'b1;
    c_part <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, 16'h2004, 8'h00, q);
    chk(q, 32'h0000_0004);
    c_part <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      c_pres <= 1'b1;
      c_rdy  <= k[3];
      c_wp   <= k[2];
      c_lvl  <= k[1:0];
      repeat (4) @(posedge clk_i);
      wb(1'b0, 16'h2004, 8'h00, q);
      chk(q, {26'h0, k[3:2], 2'h3, k[1:0]});
    end
    wb(1'b1, 16'h23C0, 8'h21, q);
    wb(1'b1, 16'h2004, 8'h00, q);
    wb(1'b0, 16'h2004, 8'h00, q);
    chk(q, 32'h0000_003F);
    chk({31'h0, isio}, 32'h1);
  endtask : t_status

  task automatic t_reset;
    logic [31:0] q;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 16'h2004, 8'h00, q);
    chk(q, 32'h0000_003F);
    chk({29'h0, legacy, pwr, isio}, 32'h0);
    wb(1'b1, 16'h2000, 8'h32, q);
    wb(1'b0, 16'h2000, 8'h00, q);
    chk(q, {24'h0, 2'h2, 2'h0, CREV});
  endtask : t_reset

  task automatic t_wprot;
    logic [31:0] q;
    wb(1'b1, 16'h2094, 8'h80, q);
    @(posedge clk_i);
    hit <= 5'h04;
    req <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, allow}, 32'h0);
    hit <= 5'h02;
    repeat (2) @(posedge clk_i);
    chk({31'h0, allow}, 32'h1);
    req <= 1'b0;
  endtask : t_wprot

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_id;
    t_status;
    t_reset;
    t_wprot;
    test_done;
  end
endmodule : card_socket_id_and_status_regs_tb_top

// [verilog/cssr_params.svh]
// Offsets, field positions, reset values for the socket id/status registers
// Assumes a 32-bit bus; each register index is a word, byte address = 4*index
`ifndef CSSR_PARAMS_SVH
`define CSSR_PARAMS_SVH

// Register indices
`define CSSR_IDX_ID         12'h800
`define CSSR_IDX_STATUS     12'h801
`define CSSR_IDX_PWR        12'h802
`define CSSR_IDX_MWOFS_BASE 12'h815
`define CSSR_MWOFS_STEP     12'h008
`define CSSR_IDX_SYSCTL     12'h8F0

// Identification register fields
`define CSSR_INTERFACE_TYPE_FIELD_VAL     2'h2
`define CSSR_COMPAT_LEGACY  4'h2
`define CSSR_ID_RSVD_RST    2'h0

// Own control register fields
`define CSSR_SYSCTL_UNLOCK  5
`define CSSR_SYSCTL_IOCARD  0
`define CSSR_SYSCTL_RST     8'h00

// Power control
`define CSSR_PWR_RST        8'h00
`define CSSR_PWR_MASK_STD   8'hB3
`define CSSR_PWR_MASK_LEG   8'h9B
`define CSSR_PWR_VCC_BIT    4

// Memory window offset high byte
`define CSSR_MWOFS_WP_BIT   7
`define CSSR_MWOFS_RST      8'h00
`define CSSR_NUM_MWIN       5

`endif

// [verilog/cssr_pin_if.sv]
// Synchronised socket pin levels passed from synchroniser to register bank
// Assumes a single clock domain on the consumer side
`timescale 1ns/1ps

interface cssr_pin_if;
  logic ready;
  logic wp;
  logic det_a_n;
  logic det_b_n;
  logic batt_a;
  logic batt_b;

  modport src (output ready, wp, det_a_n, det_b_n, batt_a, batt_b);
  modport dst (input  ready, wp, det_a_n, det_b_n, batt_a, batt_b);
endinterface : cssr_pin_if

// [verilog/cssr_pkg.sv]
// Types shared by the socket id/status register bank
// Assumes cssr_params.svh supplies the numeric constants
package cssr_pkg;

  typedef enum logic {
    CSSR_CARD_MEM,
    CSSR_CARD_IO
  } cssr_card_e;

  typedef enum logic {
    CSSR_BUS_IDLE,
    CSSR_BUS_ACK
  } cssr_bus_e;

  typedef struct packed {
    logic       rsvd;
    logic       power;
    logic       ready;
    logic       wprot;
    logic       det_b;
    logic       det_a;
    logic [1:0] level;
  } cssr_status_s;

endpackage : cssr_pkg

// [verilog/cssr_regs.sv]
// Socket identification/revision and interface status registers
// Assumes a classic Wishbone master on clk_i; pins are asynchronous
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps

`include "cssr_params.svh"

module cssr_regs #(
  parameter int         ADR_W      = 16,
  parameter logic [3:0] COMPAT_REV = 4'h1 // Arbitrary value
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [ADR_W-1:0]          wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      card_ready_i,
  input  wire logic                      card_wp_i,
  input  wire logic                      card_detect_a_pin_n_i,
  input  wire logic                      card_detect_b_pin_n_i,
  input  wire logic                      battery_detect_a_i,
  input  wire logic                      battery_detect_b_i,
  input  wire logic [`CSSR_NUM_MWIN-1:0] mem_win_hit_i,
  input  wire logic                      mem_wr_req_i,
  output logic                           mem_wr_allow_o,
  output logic                           legacy_mode_o,
  output logic                           socket_power_o,
  output logic                           card_is_io_o
);

  cssr_pin_if pins ();

  cssr_sync u_sync (
    .clk_i                 (clk_i),
    .card_ready_i          (card_ready_i),
    .card_wp_i             (card_wp_i),
    .card_detect_a_pin_n_i (card_detect_a_pin_n_i),
    .card_detect_b_pin_n_i (card_detect_b_pin_n_i),
    .battery_detect_a_i    (battery_detect_a_i),
    .battery_detect_b_i    (battery_detect_b_i),
    .pins                  (pins)
  );

  // Register index match on a byte address; upper bits must be zero
  function automatic logic idx_hit(input logic [ADR_W-1:0] adr,
                                   input logic [11:0]      idx);
    logic [ADR_W-1:0] full;
    full    = {{(ADR_W-14){1'b0}}, idx, 2'b00};
    idx_hit = (adr[ADR_W-1:2] == full[ADR_W-1:2]);
  endfunction : idx_hit

  // One-hot memory window flag for an offset-high-byte index, or none
  function automatic logic [`CSSR_NUM_MWIN-1:0] mwin_dec(input logic [ADR_W-1:0] adr);
    logic [`CSSR_NUM_MWIN-1:0] v;
    v = '0;
    for (int k = 0; k < `CSSR_NUM_MWIN; k++) begin
      if (idx_hit(adr, 12'(`CSSR_IDX_MWOFS_BASE + k * `CSSR_MWOFS_STEP))) begin
        v[k] = 1'b1;
      end
    end
    mwin_dec = v;
  endfunction : mwin_dec

  // Bus handshake
  cssr_pkg::cssr_bus_e bus_q;
  cssr_pkg::cssr_bus_e bus_d;
  logic [31:0]         rdat_q;
  logic [31:0]         rdat_d;

  // Register state
  logic [1:0]  id_rsvd_q;
  logic [1:0]  id_rsvd_d;
  logic [3:0]  rev_q;
  logic [3:0]  rev_d;
  logic [7:0]  pwr_q;
  logic [7:0]  pwr_d;
  logic [7:0]  sysctl_q;
  logic [7:0]  sysctl_d;
  logic [7:0]  mwofs_q [`CSSR_NUM_MWIN];
  logic [7:0]  mwofs_d [`CSSR_NUM_MWIN];
  logic        legacy_q;
  logic        legacy_d;
  logic        allow_q;
  logic        allow_d;

  logic                          req;
  logic                          wr;
  logic [7:0]                    wbyte;
  logic [7:0]                    id_val;
  logic [`CSSR_NUM_MWIN-1:0]     mw_sel;
  logic [`CSSR_NUM_MWIN-1:0]     mw_prot;
  logic                          allow_c;
  cssr_pkg::cssr_status_s        status;
  cssr_pkg::cssr_card_e          card;

  assign req   = wb_cyc_i & wb_stb_i & (bus_q == cssr_pkg::CSSR_BUS_IDLE);
  assign wr    = req & wb_we_i & wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign mw_sel = mwin_dec(wb_adr_i);

  assign card = sysctl_q[`CSSR_SYSCTL_IOCARD] ? cssr_pkg::CSSR_CARD_IO
                                              : cssr_pkg::CSSR_CARD_MEM;

  // Identification value
  assign id_val = {`CSSR_INTERFACE_TYPE_FIELD_VAL, id_rsvd_q, rev_q};

  // Live status byte
  always_comb begin
    status       = '0;
    status.rsvd  = 1'b0;
    status.power = pwr_q[`CSSR_PWR_VCC_BIT];
    status.ready = pins.ready;
    status.wprot = pins.wp;
    status.det_b = ~pins.det_b_n;
    status.det_a = ~pins.det_a_n;
    if (card == cssr_pkg::CSSR_CARD_MEM) begin
      status.level = {pins.batt_b, pins.batt_a};
    end else begin
      status.level = {pins.batt_b, pins.batt_a};
    end
  end

  for (genvar g = 0; g < `CSSR_NUM_MWIN; g++) begin : g_prot
    assign mw_prot[g] = mwofs_q[g][`CSSR_MWOFS_WP_BIT];
  end

  cssr_wprot #(
    .NWIN (`CSSR_NUM_MWIN)
  ) u_wprot (
    .prot_i   (mw_prot),
    .hit_i    (mem_win_hit_i),
    .wr_req_i (mem_wr_req_i),
    .allow_o  (allow_c)
  );

  // Bus handshake and read data
  always_comb begin
    bus_d  = bus_q;
    rdat_d = rdat_q;
    case (bus_q)
      cssr_pkg::CSSR_BUS_IDLE: begin
        if (wb_cyc_i & wb_stb_i) begin
          bus_d  = cssr_pkg::CSSR_BUS_ACK;
          rdat_d = 32'h0000_0000;
          if (idx_hit(wb_adr_i, `CSSR_IDX_ID)) begin
            rdat_d[7:0] = id_val;
          end else if (idx_hit(wb_adr_i, `CSSR_IDX_STATUS)) begin
            rdat_d[7:0] = status;
          end else if (idx_hit(wb_adr_i, `CSSR_IDX_PWR)) begin
            rdat_d[7:0] = pwr_q;
          end else if (idx_hit(wb_adr_i, `CSSR_IDX_SYSCTL)) begin
            rdat_d[7:0] = sysctl_q;
          end else begin
            for (int k = 0; k < `CSSR_NUM_MWIN; k++) begin
              if (mw_sel[k]) begin
                rdat_d[7:0] = mwofs_q[k];
              end
            end
          end
        end
      end
      cssr_pkg::CSSR_BUS_ACK: begin
        bus_d = cssr_pkg::CSSR_BUS_IDLE;
      end
      default: begin
        bus_d = cssr_pkg::CSSR_BUS_IDLE;
      end
    endcase
    if (rst_i) begin
      bus_d  = cssr_pkg::CSSR_BUS_IDLE;
      rdat_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    bus_q  <= bus_d;
    rdat_q <= rdat_d;
  end

  // Register writes
  always_comb begin
    id_rsvd_d = id_rsvd_q;
    rev_d     = rev_q;
    pwr_d     = pwr_q;
    sysctl_d  = sysctl_q;
    legacy_d  = legacy_q;
    for (int k = 0; k < `CSSR_NUM_MWIN; k++) begin
      mwofs_d[k] = mwofs_q[k];
    end
    if (wr) begin
      if (idx_hit(wb_adr_i, `CSSR_IDX_ID) && sysctl_q[`CSSR_SYSCTL_UNLOCK]) begin
        id_rsvd_d = wbyte[5:4];
        rev_d     = wbyte[3:0];
        legacy_d  = (wbyte[3:0] == `CSSR_COMPAT_LEGACY);
      end
      if (idx_hit(wb_adr_i, `CSSR_IDX_PWR)) begin
        // Writable bits depend on the active power field layout
        if (legacy_q) begin
          pwr_d = wbyte & `CSSR_PWR_MASK_LEG;
        end else begin
          pwr_d = wbyte & `CSSR_PWR_MASK_STD;
        end
      end
      if (idx_hit(wb_adr_i, `CSSR_IDX_SYSCTL)) begin
        sysctl_d = wbyte;
      end
      for (int k = 0; k < `CSSR_NUM_MWIN; k++) begin
        if (mw_sel[k]) begin
          mwofs_d[k] = wbyte;
        end
      end
    end
    if (rst_i) begin
      id_rsvd_d = `CSSR_ID_RSVD_RST;
      rev_d     = COMPAT_REV;
      pwr_d     = `CSSR_PWR_RST;
      sysctl_d  = `CSSR_SYSCTL_RST;
      legacy_d  = (COMPAT_REV == `CSSR_COMPAT_LEGACY);
      for (int k = 0; k < `CSSR_NUM_MWIN; k++) begin
        mwofs_d[k] = `CSSR_MWOFS_RST;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    id_rsvd_q <= id_rsvd_d;
    rev_q     <= rev_d;
    pwr_q     <= pwr_d;
    sysctl_q  <= sysctl_d;
    legacy_q  <= legacy_d;
    for (int k = 0; k < `CSSR_NUM_MWIN; k++) begin
      mwofs_q[k] <= mwofs_d[k];
    end
  end

  // Registered write-permit for the memory path
  always_comb begin
    allow_d = rst_i ? 1'b0 : allow_c;
  end

  always_ff @(posedge clk_i) begin
    allow_q <= allow_d;
  end

  assign wb_ack_o       = (bus_q == cssr_pkg::CSSR_BUS_ACK);
  assign wb_dat_o       = rdat_q;
  assign mem_wr_allow_o = allow_q;
  assign legacy_mode_o  = legacy_q;
  assign socket_power_o = pwr_q[`CSSR_PWR_VCC_BIT];
  assign card_is_io_o   = sysctl_q[`CSSR_SYSCTL_IOCARD];

endmodule : cssr_regs

// [verilog/cssr_sync.sv]
// Two-flop synchroniser for the socket status pins
// Assumes raw pins are asynchronous to clk_i
`timescale 1ns/1ps

module cssr_sync (
  input  wire logic clk_i,
  input  wire logic card_ready_i,
  input  wire logic card_wp_i,
  input  wire logic card_detect_a_pin_n_i,
  input  wire logic card_detect_b_pin_n_i,
  input  wire logic battery_detect_a_i,
  input  wire logic battery_detect_b_i,
  cssr_pin_if.src   pins
);

  logic [5:0] raw;
  logic [5:0] meta_q;
  logic [5:0] meta_d;
  logic [5:0] sync_q;
  logic [5:0] sync_d;

  assign raw = {card_ready_i, card_wp_i, card_detect_a_pin_n_i,
                card_detect_b_pin_n_i, battery_detect_a_i, battery_detect_b_i};

  // No reset: status shows live pins right after reset
  always_comb begin
    meta_d = raw;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign pins.ready   = sync_q[5];
  assign pins.wp      = sync_q[4];
  assign pins.det_a_n = sync_q[3];
  assign pins.det_b_n = sync_q[2];
  assign pins.batt_a  = sync_q[1];
  assign pins.batt_b  = sync_q[0];

endmodule : cssr_sync

// [verilog/cssr_wprot.sv]
// Memory window write-protect gate
// Assumes window hit flags come from the same-clock memory decode
`timescale 1ns/1ps

module cssr_wprot #(
  parameter int NWIN = 5
) (
  input  wire logic [NWIN-1:0] prot_i,
  input  wire logic [NWIN-1:0] hit_i,
  input  wire logic            wr_req_i,
  output logic                 allow_o
);

  // Any hit window that is protected blocks the write
  always_comb begin
    allow_o = wr_req_i & ~|(prot_i & hit_i);
  end

endmodule : cssr_wprot
